// ==== pin_sync.sv ====
// two-flop pin synchroniser with synchronous clear
`default_nettype none
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // clear to idle level
   input wire logic clr,
   // pin and synchronised copy
   input wire logic d,
   output logic q
);
   logic meta_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q <= INIT;
      end else if (clr) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ==== spi_master_model.sv ====
// serial master model that sends command frames to the slave
`default_nettype none
module spi_master_model (
   // clock
   input wire logic sys_clk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 8;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   // command byte then eight data clocks, mode 0, msb first
   task automatic frame(input logic [7:0] cmd, output logic [7:0] rx);
      logic [15:0] sh;
      sh = {cmd, 8'h00};
      rx = 8'h00;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (HALF) @(posedge sys_clk);
      for (int i = 15; i >= 0; i--) begin
         mosi <= sh[i];
         repeat (HALF) @(posedge sys_clk);
         sclk <= 1'b1;
         @(posedge sys_clk);
         rx = {rx[6:0], (miso_oe === 1'b1) ? miso : 1'bx};
         repeat (HALF - 1) @(posedge sys_clk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      cs_n <= 1'b1;
      // released line shows the inverse of its last value
      mosi <= ~mosi;
      repeat (2 * HALF) @(posedge sys_clk);
   endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ==== spi_slave_mode_control.sv ====
// serial unit role, slave command decode and status control
// Behaviour
// - software reset clears latched line copies
// - role bit: 1 slave, 0 master
// - buffer commands only while buffer enable
// - status commands only while status enable
// - custom select uses programmed command codes
// - fixed codes 1,2,3,4 otherwise
// - read-only counter of master-role transfers and accepted slave commands
// - slave state machine state readable
// - low three bits of last received command captured, readable
// - chip-select mode: delay, sync+delay, sync
// - five separate interrupt enable bits
// - five writable raw done bits
// - custom register holds four command codes
//
// Register access over AHB-Lite was decided locally.
`default_nettype none
module spi_slave_mode_control
   import spi_slave_mode_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe,
   // master engine
   input wire logic master_xfer_done,
   // status
   output logic slave_mode,
   output logic spi_irq
);
   logic wr_pend_reg, rd_wait_reg;
   logic [7:0] wr_addr_reg, rd_addr_reg;
   logic [31:0] hrdata_reg;
   logic sync_rst_reg, slave_reg, buf_en_reg, sta_en_reg, cmd_sel_reg;
   logic [3:0] cnt_reg;
   logic [2:0] lcmd_reg;
   logic [1:0] csmode_reg;
   logic [NEV-1:0] ien_reg, raw_reg, ev;
   logic [31:0] custom_reg;
   logic [3:0] dly_num_reg;
   logic dly_mode_reg;
   logic sclk_s, cs_n_s, mosi_s;
   logic sclk_prev_reg, cs_prev_reg, filt_n_reg, cs_act_reg;
   logic [3:0] dly_cnt_reg;
   slv_state_e state_reg;
   cmd_kind_e kind_reg, kind_dec;
   logic [2:0] bit_cnt_reg;
   logic [7:0] cmd_sh_reg, byte_next;
   logic [8:0] tx_sh_reg;
   logic wr_ctrl, wr_custom, wr_cscfg, addr_ok;
   logic slave_act, sclk_rise, sclk_fall, cmd_done, cs_pre_act, dly_edge;
   logic [7:0] c_wrsta, c_rdsta, c_wrbuf, c_rdbuf;

   // bus address phase and one wait state on reads
   assign addr_ok = hsel && htrans[1] && hready;
   assign hreadyout = !rd_wait_reg;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
   assign wr_custom = wr_pend_reg && (wr_addr_reg == OFS_CUSTOM);
   assign wr_cscfg = wr_pend_reg && (wr_addr_reg == OFS_CSCFG);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ok && hwrite && (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h000000);
         rd_wait_reg <= addr_ok && !hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[7:0];
            rd_addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
         end
      end
   end

   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h00000000;
      if (a == OFS_CTRL) begin
         v[B_SYNC_RST] = sync_rst_reg;
         v[B_SLAVE] = slave_reg;
         v[B_BUF_EN] = buf_en_reg;
         v[B_STA_EN] = sta_en_reg;
         v[B_CMD_SEL] = cmd_sel_reg;
         v[F_CNT +: 4] = cnt_reg;
         v[F_STATE +: 3] = state_reg;
         v[F_LCMD +: 3] = lcmd_reg;
         v[F_CSMODE +: 2] = csmode_reg;
         v[F_IEN +: NEV] = ien_reg;
         v[F_RAW +: NEV] = raw_reg;
      end else if (a == OFS_CUSTOM) begin
         v = custom_reg;
      end else if (a == OFS_CSCFG) begin
         v[F_DLY_NUM +: 4] = dly_num_reg;
         v[B_DLY_MODE] = dly_mode_reg;
      end
      return v;
   endfunction : rd_mux
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_reg <= 32'h00000000;
      end else if (rd_wait_reg) begin
         hrdata_reg <= rd_mux(rd_addr_reg);
      end
   end

   // software control fields
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_rst_reg <= 1'b0;
         slave_reg <= 1'b0;
         buf_en_reg <= 1'b0;
         sta_en_reg <= 1'b0;
         cmd_sel_reg <= 1'b0;
         csmode_reg <= CSM_DELAY;
         ien_reg <= '0;
      end else if (wr_ctrl) begin
         sync_rst_reg <= hwdata[B_SYNC_RST];
         slave_reg <= hwdata[B_SLAVE];
         buf_en_reg <= hwdata[B_BUF_EN];
         sta_en_reg <= hwdata[B_STA_EN];
         cmd_sel_reg <= hwdata[B_CMD_SEL];
         csmode_reg <= hwdata[F_CSMODE +: 2];
         ien_reg <= hwdata[F_IEN +: NEV];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         custom_reg <= 32'h00000000;
         dly_num_reg <= 4'h0;
         dly_mode_reg <= 1'b0;
      end else begin
         if (wr_custom) begin
            custom_reg <= hwdata;
         end
         if (wr_cscfg) begin
            dly_num_reg <= hwdata[F_DLY_NUM +: 4];
            dly_mode_reg <= hwdata[B_DLY_MODE];
         end
      end
   end

   // raw done bits: hardware set wins over a software write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_reg <= '0;
      end else if (wr_ctrl) begin
         raw_reg <= hwdata[F_RAW +: NEV] | ev;
      end else begin
         raw_reg <= raw_reg | ev;
      end
   end

   assign spi_irq = |(raw_reg & ien_reg);
   assign slave_mode = slave_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
      end else if (ev[EV_XFER]) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   // pin synchronisers, cleared by software reset
   pin_sync #(.INIT(1'b0)) u_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .clr(sync_rst_reg),
      .d(sclk_in), .q(sclk_s));
   pin_sync #(.INIT(1'b1)) u_cs (.sys_clk(sys_clk), .rst_n(rst_n), .clr(sync_rst_reg),
      .d(cs_n_in), .q(cs_n_s));
   pin_sync #(.INIT(1'b0)) u_mosi (.sys_clk(sys_clk), .rst_n(rst_n), .clr(sync_rst_reg),
      .d(mosi_in), .q(mosi_s));

   // chip-select filter and delay
   assign cs_pre_act = (csmode_reg == CSM_DELAY) ? !cs_n_s : !filt_n_reg;
   assign dly_edge = (csmode_reg != CSM_SYNC) && (cs_pre_act || dly_mode_reg);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_reg <= 1'b1;
         filt_n_reg <= 1'b1;
         cs_act_reg <= 1'b0;
         dly_cnt_reg <= 4'h0;
         sclk_prev_reg <= 1'b0;
      end else if (sync_rst_reg) begin
         cs_prev_reg <= 1'b1;
         filt_n_reg <= 1'b1;
         cs_act_reg <= 1'b0;
         dly_cnt_reg <= 4'h0;
         sclk_prev_reg <= 1'b0;
      end else begin
         cs_prev_reg <= cs_n_s;
         sclk_prev_reg <= sclk_s;
         if (cs_prev_reg == cs_n_s) begin
            filt_n_reg <= cs_n_s;
         end
         if (cs_pre_act == cs_act_reg) begin
            dly_cnt_reg <= 4'h0;
         end else if (!dly_edge || (dly_cnt_reg >= dly_num_reg)) begin
            cs_act_reg <= cs_pre_act;
            dly_cnt_reg <= 4'h0;
         end else begin
            dly_cnt_reg <= dly_cnt_reg + 4'h1;
         end
      end
   end

   assign slave_act = slave_reg && !sync_rst_reg;
   assign sclk_rise = sclk_s && !sclk_prev_reg;
   assign sclk_fall = !sclk_s && sclk_prev_reg;
   assign byte_next = {cmd_sh_reg[6:0], mosi_s};
   assign cmd_done = slave_act && cs_act_reg && (state_reg == ST_CMD) && sclk_rise && (bit_cnt_reg == CMD_LAST_BIT);
   assign c_wrsta = cmd_sel_reg ? custom_reg[F_WRSTA +: 8] : FIX_WRSTA;
   assign c_rdsta = cmd_sel_reg ? custom_reg[F_RDSTA +: 8] : FIX_RDSTA;
   assign c_wrbuf = cmd_sel_reg ? custom_reg[F_WRBUF +: 8] : FIX_WRBUF;
   assign c_rdbuf = cmd_sel_reg ? custom_reg[F_RDBUF +: 8] : FIX_RDBUF;

   always_comb begin
      kind_dec = K_NONE;
      if (sta_en_reg && (byte_next == c_wrsta)) begin
         kind_dec = K_WRSTA;
      end else if (sta_en_reg && (byte_next == c_rdsta)) begin
         kind_dec = K_RDSTA;
      end else if (buf_en_reg && (byte_next == c_wrbuf)) begin
         kind_dec = K_WRBUF;
      end else if (buf_en_reg && (byte_next == c_rdbuf)) begin
         kind_dec = K_RDBUF;
      end
   end

   // slave frame state machine
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         kind_reg <= K_NONE;
         bit_cnt_reg <= 3'h0;
         cmd_sh_reg <= 8'h00;
      end else if (!slave_act) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               bit_cnt_reg <= 3'h0;
               if (cs_act_reg) begin
                  state_reg <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (!cs_act_reg) begin
                  state_reg <= ST_IDLE;
               end else if (sclk_rise) begin
                  cmd_sh_reg <= byte_next;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (cmd_done) begin
                     kind_reg <= kind_dec;
                     case (kind_dec)
                        K_WRSTA, K_WRBUF: state_reg <= ST_WRDATA;
                        K_RDSTA, K_RDBUF: state_reg <= ST_RDDATA;
                        default: state_reg <= ST_WAIT;
                     endcase
                  end
               end
            end
            ST_WRDATA, ST_RDDATA: begin
               if (!cs_act_reg) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_WAIT: begin
               if (!cs_act_reg) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lcmd_reg <= 3'h0;
      end else if (cmd_done) begin
         lcmd_reg <= byte_next[2:0];
      end
   end
   // completion events
   always_comb begin
      ev = '0;
      ev[EV_XFER] = (state_reg == ST_DONE) || (master_xfer_done && !slave_reg);
      if (state_reg == ST_DONE) begin
         ev[EV_WRSTA] = (kind_reg == K_WRSTA);
         ev[EV_RDSTA] = (kind_reg == K_RDSTA);
         ev[EV_WRBUF] = (kind_reg == K_WRBUF);
         ev[EV_RDBUF] = (kind_reg == K_RDBUF);
      end
   end

   // read reply, status only; spare top bit absorbs the fall after the last command bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_reg <= 9'h000;
      end else if (cmd_done) begin
         tx_sh_reg <= (kind_dec == K_RDSTA) ? {4'h0, raw_reg} : 9'h000;
      end else if ((state_reg == ST_RDDATA) && sclk_fall) begin
         tx_sh_reg <= {tx_sh_reg[7:0], 1'b0};
      end
   end

   assign miso_out = tx_sh_reg[8];
   assign miso_oe = (state_reg == ST_RDDATA);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sync_clear_a: assert property (sync_rst_reg |=> !sclk_s && cs_n_s && !mosi_s && !cs_act_reg)
      else $error("software reset did not clear line copies");
   role_gate_a: assert property (!slave_reg |=> state_reg == ST_IDLE && !miso_oe)
      else $error("slave machine active in master role");
   buf_gate_a: assert property (cmd_done && !buf_en_reg |=> kind_reg != K_WRBUF && kind_reg != K_RDBUF)
      else $error("buffer command accepted while disabled");
   sta_gate_a: assert property (cmd_done && !sta_en_reg |=> kind_reg != K_WRSTA && kind_reg != K_RDSTA)
      else $error("status command accepted while disabled");
   custom_cmd_a: assert property (cmd_done && cmd_sel_reg && sta_en_reg
      && byte_next == custom_reg[F_WRSTA +: 8] |=> kind_reg == K_WRSTA && state_reg == ST_WRDATA)
      else $error("custom write-status code not decoded");
   fixed_cmd_a: assert property (cmd_done && !cmd_sel_reg && buf_en_reg
      && byte_next == FIX_RDBUF |=> kind_reg == K_RDBUF ##1 miso_oe)
      else $error("fixed read-buffer code not decoded");
   op_count_a: assert property (ev[EV_XFER] |=> cnt_reg == $past(cnt_reg) + 4'h1)
      else $error("operation counter did not advance");
   state_field_a: assert property (rd_wait_reg && rd_addr_reg == OFS_CTRL
      |=> hrdata[F_STATE +: 3] == $past(state_reg) && hreadyout)
      else $error("state field does not match machine");
   last_cmd_a: assert property (cmd_done |=> lcmd_reg == 3'($past(byte_next)))
      else $error("received command not captured");
   cs_sync_a: assert property (csmode_reg == CSM_SYNC && !sync_rst_reg && (!filt_n_reg != cs_act_reg)
      |=> cs_act_reg == !$past(filt_n_reg))
      else $error("sync-only chip select was delayed");
   raw_set_a: assert property (|ev |=> (raw_reg & $past(ev)) == $past(ev))
      else $error("done event lost");
   irq_rise_a: assert property ($rose(spi_irq) |-> |$past(ev) || $past(wr_ctrl))
      else $error("interrupt rose without cause");

   wrbuf_done_c: cover property (state_reg == ST_DONE && kind_reg == K_WRBUF);
   rdsta_done_c: cover property (state_reg == ST_DONE && kind_reg == K_RDSTA);
   master_cnt_c: cover property (master_xfer_done && !slave_reg);
   irq_c: cover property ($rose(spi_irq));
endmodule : spi_slave_mode_control
`default_nettype wire

// ==== spi_slave_mode_pkg.sv ====
// constants for the serial slave mode control block
`default_nettype none
package spi_slave_mode_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h38;
   localparam logic [7:0] OFS_CUSTOM = 8'h44;
   localparam logic [7:0] OFS_CSCFG = 8'h50;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int B_SYNC_RST = 31;
   localparam int B_SLAVE = 30;
   localparam int B_BUF_EN = 29;
   localparam int B_STA_EN = 28;
   localparam int B_CMD_SEL = 27;
   localparam int F_CNT = 23;
   localparam int F_STATE = 20;
   localparam int F_LCMD = 17;
   localparam int F_CSMODE = 10;
   localparam int F_IEN = 5;
   localparam int F_RAW = 0;
   localparam int F_WRSTA = 24;
   localparam int F_RDSTA = 16;
   localparam int F_WRBUF = 8;
   localparam int F_RDBUF = 0;
   localparam int F_DLY_NUM = 0;
   localparam int B_DLY_MODE = 4;
   localparam int NEV = 5;
   localparam int EV_XFER = 4;
   localparam int EV_WRSTA = 3;
   localparam int EV_RDSTA = 2;
   localparam int EV_WRBUF = 1;
   localparam int EV_RDBUF = 0;
   localparam logic [7:0] FIX_WRSTA = 8'h01;
   localparam logic [7:0] FIX_WRBUF = 8'h02;
   localparam logic [7:0] FIX_RDBUF = 8'h03;
   localparam logic [7:0] FIX_RDSTA = 8'h04;
   localparam logic [1:0] CSM_DELAY = 2'h0;
   localparam logic [1:0] CSM_BOTH = 2'h1;
   localparam logic [1:0] CSM_SYNC = 2'h2;
   localparam logic [2:0] CMD_LAST_BIT = 3'h7;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WRDATA, ST_RDDATA, ST_WAIT, ST_DONE} slv_state_e;
   typedef enum logic [2:0] {K_NONE, K_WRSTA, K_RDSTA, K_WRBUF, K_RDBUF} cmd_kind_e;
endpackage : spi_slave_mode_pkg
`default_nettype wire

// ==== tb_spi_slave_mode_control.sv ====
// testbench for the serial slave mode control block
`default_nettype none
module tb_spi_slave_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   import spi_slave_mode_pkg::*;
   logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, sclk_in, cs_n_in, mosi_in, miso_out, miso_oe;
   logic master_xfer_done, slave_mode, spi_irq;
   logic [31:0] haddr, hwdata, hrdata, ctl, d;
   logic [1:0] htrans;
   logic [2:0] hsize, lcmd;
   logic [4:0] raw;
   logic [3:0] cnt;
   logic [7:0] rx;
   int errors, samples_checked;
   spi_slave_mode_control uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .mosi_in(mosi_in), .miso_out(miso_out),
      .miso_oe(miso_oe), .master_xfer_done(master_xfer_done), .slave_mode(slave_mode), .spi_irq(spi_irq));
   spi_master_model pm (.sys_clk(sys_clk), .sclk(sclk_in), .cs_n(cs_n_in), .mosi(mosi_in), .miso(miso_out),
      .miso_oe(miso_oe));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      samples_checked++;
      if ((got & mask) !== (exp & mask)) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         summarize();
      end
   endtask : wait_rdy
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   function automatic logic [31:0] exp_ctrl();
      return ctl | (32'(cnt) << F_CNT) | (32'(lcmd) << F_LCMD) | 32'(raw);
   endfunction : exp_ctrl
   task automatic wr_ctl();
      ahb(1'b1, 32'(OFS_CTRL), ctl | 32'(raw), d);
      repeat (2) @(posedge sys_clk);
   endtask : wr_ctl
   task automatic chk_ctl(input logic [31:0] mask);
      ahb(1'b0, 32'(OFS_CTRL), 32'h0, d);
      chk(d, exp_ctrl(), mask);
   endtask : chk_ctl
   task automatic t_reset_role();
      chk_ctl(32'hFFFFFFFF);
      chk({31'h0, slave_mode}, 32'h0, 32'h1);
      ctl = 32'h70000000 | (32'h1F << F_IEN);
      wr_ctl();
      chk({31'h0, slave_mode}, 32'h1, 32'h1);
      chk_ctl(32'hFFFFFFFF);
      ahb(1'b1, 32'(OFS_CSCFG), 32'h12, d);
      ahb(1'b0, 32'(OFS_CSCFG), 32'h0, d);
      chk(d, 32'h12, 32'hFFFFFFFF);
   endtask : t_reset_role
   task automatic t_fixed();
      logic [7:0] codes [4] = '{FIX_WRSTA, FIX_WRBUF, FIX_RDBUF, FIX_RDSTA};
      int kinds [4] = '{EV_WRSTA, EV_WRBUF, EV_RDBUF, EV_RDSTA};
      logic [1:0] modes [4] = '{CSM_DELAY, CSM_BOTH, CSM_SYNC, CSM_DELAY};
      logic [4:0] prev;
      for (int i = 0; i < 4; i++) begin
         ctl[11:10] = modes[i];
         wr_ctl();
         prev = raw;
         fork
            pm.frame(codes[i], rx);
            begin
               repeat (40) @(posedge sys_clk);
               ahb(1'b0, 32'(OFS_CTRL), 32'h0, d);
               chk(d, 32'h1 << F_STATE, 32'h7 << F_STATE);
            end
         join
         cnt++;
         lcmd = codes[i][2:0];
         raw = raw | (5'h1 << EV_XFER) | (5'h1 << kinds[i]);
         chk_ctl(32'hFFFFFFFF);
      end
      chk({24'h0, rx}, {27'h0, prev}, 32'hFF);
      chk({31'h0, spi_irq}, 32'h1, 32'h1);
   endtask : t_fixed
   task automatic t_irq();
      raw = 5'h00;
      wr_ctl();
      chk_ctl(32'hFFFFFFFF);
      chk({31'h0, spi_irq}, 32'h0, 32'h1);
      raw = 5'h04;
      wr_ctl();
      chk_ctl(32'hFFFFFFFF);
      chk({31'h0, spi_irq}, 32'h1, 32'h1);
      ctl[9:5] = 5'h1B;
      wr_ctl();
      chk({31'h0, spi_irq}, 32'h0, 32'h1);
      ctl[9:5] = 5'h1F;
      raw = 5'h00;
      wr_ctl();
   endtask : t_irq
   task automatic t_refuse();
      ctl[B_BUF_EN] = 1'b0;
      wr_ctl();
      pm.frame(FIX_WRBUF, rx);
      pm.frame(FIX_RDBUF, rx);
      lcmd = FIX_RDBUF[2:0];
      chk_ctl(32'hFFFFFFFF);
      ctl[B_BUF_EN] = 1'b1;
      ctl[B_STA_EN] = 1'b0;
      wr_ctl();
      pm.frame(FIX_WRSTA, rx);
      pm.frame(FIX_RDSTA, rx);
      lcmd = FIX_RDSTA[2:0];
      chk_ctl(32'hFFFFFFFF);
      ctl[B_STA_EN] = 1'b1;
      wr_ctl();
   endtask : t_refuse
   task automatic t_custom();
      ahb(1'b1, 32'(OFS_CUSTOM), 32'hA55A3CC3, d);
      ahb(1'b0, 32'(OFS_CUSTOM), 32'h0, d);
      chk(d, 32'hA55A3CC3, 32'hFFFFFFFF);
      ctl[B_CMD_SEL] = 1'b1;
      wr_ctl();
      pm.frame(8'hA5, rx);
      pm.frame(FIX_WRBUF, rx);
      pm.frame(8'h5A, rx);
      chk({24'h0, rx}, 32'h18, 32'hFF);
      cnt = cnt + 4'h2;
      lcmd = 3'h2;
      raw = 5'h1C;
      chk_ctl(32'hFFFFFFFF);
      ctl[B_CMD_SEL] = 1'b0;
      raw = 5'h00;
      wr_ctl();
   endtask : t_custom
   task automatic t_master_sync();
      ctl[B_SLAVE] = 1'b0;
      wr_ctl();
      master_xfer_done <= 1'b1;
      @(posedge sys_clk);
      master_xfer_done <= 1'b0;
      pm.frame(FIX_WRBUF, rx);
      cnt++;
      raw = 5'h10;
      chk_ctl(32'hFFFFFFFF);
      ctl[B_SLAVE] = 1'b1;
      ctl[B_SYNC_RST] = 1'b1;
      wr_ctl();
      pm.frame(FIX_WRBUF, rx);
      chk_ctl(32'hFFFFFFFF);
      ctl[B_SYNC_RST] = 1'b0;
      raw = 5'h00;
      wr_ctl();
      pm.frame(FIX_RDBUF, rx);
      cnt++;
      lcmd = FIX_RDBUF[2:0];
      raw = 5'h11;
      chk_ctl(32'hFFFFFFFF);
      ahb(1'b1, 32'h60, 32'hFFFFFFFF, d);
      ahb(1'b0, 32'h60, 32'h0, d);
      chk(d, 32'h0, 32'hFFFFFFFF);
      chk({31'h0, hresp}, 32'h0, 32'h1);
   endtask : t_master_sync
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      master_xfer_done = 1'b0;
      errors = 0;
      samples_checked = 0;
      ctl = 32'h0;
      raw = 5'h00;
      cnt = 4'h0;
      lcmd = 3'h0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset_role();
      t_fixed();
      t_irq();
      t_refuse();
      t_custom();
      t_master_sync();
      summarize();
   end
endmodule : tb_spi_slave_mode_control
`default_nettype wire
